/* hdl/ssap_top.sv */
// two-wire slave: protocol engine, address pointer, busy and boot timing
`timescale 1ns/10ps
module ssap_top #(
    parameter int BOOT_CYCLES = ssap_pkg::BOOT_CYCLES,
    parameter int EE_WRITE_CYCLES = ssap_pkg::EE_WRITE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic address_select_pin,
    output logic sda_out,
    output logic sda_oe,
    output logic busy
);

    // ****************************************
    // reference domain: boot and write timing
    // ****************************************
    logic [1:0] ev_ref;
    logic [1:0] ev_ref_q;
    logic [ssap_pkg::TIMER_W-1:0] timer;
    logic [ssap_pkg::TIMER_W-1:0] next_timer;
    logic next_busy;
    logic ee_tgl;
    logic boot_tgl;

    ssap_sync #(.W(2)) u_ev_sync (
        .clk(ref_clk),
        .d({boot_tgl, ee_tgl}),
        .q(ev_ref)
    );

    always_comb begin
        next_timer = timer;
        if (timer != '0) begin
            next_timer = timer - 1'b1;
        end
        if (ev_ref[0] != ev_ref_q[0] && next_timer < EE_WRITE_CYCLES[ssap_pkg::TIMER_W-1:0]) begin
            next_timer = EE_WRITE_CYCLES[ssap_pkg::TIMER_W-1:0];
        end
        if (ev_ref[1] != ev_ref_q[1]) begin
            next_timer = BOOT_CYCLES[ssap_pkg::TIMER_W-1:0];
        end
        next_busy = (next_timer != '0);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer <= BOOT_CYCLES[ssap_pkg::TIMER_W-1:0];
            busy <= 1'b1;
            ev_ref_q <= 2'h0;
        end else begin
            timer <= next_timer;
            busy <= next_busy;
            ev_ref_q <= ev_ref;
        end
    end

    // ****************************************
    // link domain: pin and level crossing
    // ****************************************
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic rst_l;
    logic busy_l;

    ssap_sync #(.W(4)) u_pin_sync (
        .clk(link_clk),
        .d({rst, address_select_pin, scl, sda_in}),
        .q({rst_l, sel_s, scl_s, sda_s})
    );

    ssap_sync #(.W(1)) u_busy_sync (
        .clk(link_clk),
        .d(busy),
        .q(busy_l)
    );

    // ****************************************
    // link domain: state
    // ****************************************
    ssap_pkg::ssap_state_t state;
    ssap_pkg::ssap_state_t next_state;
    ssap_pkg::ssap_phase_t phase;
    ssap_pkg::ssap_phase_t next_phase;
    ssap_pkg::ssap_mem_wr_t wr;
    ssap_pkg::ssap_mem_wr_t next_wr;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [3:0] bitcnt;
    logic [3:0] next_bitcnt;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic rw;
    logic next_rw;
    logic brd_armed;
    logic next_brd_armed;
    logic tx_is_cnt;
    logic next_tx_is_cnt;
    logic mack_ok;
    logic next_mack_ok;
    logic next_sda_oe;
    logic next_ee_tgl;
    logic next_boot_tgl;
    logic scl_q;
    logic sda_q;
    logic [7:0] rdata;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;

    ssap_mem #(.AW(8)) u_mem (
        .clk(link_clk),
        .wr(wr),
        .raddr(ptr),
        .rdata(rdata)
    );

    // pointer step that holds at REG_HI and CEE_HI; at UEE_HI it moves on into the config region
    function automatic logic [7:0] step_ptr(input logic [7:0] p);
        if (p == ssap_pkg::REG_HI || p == ssap_pkg::CEE_HI) begin
            step_ptr = p;
        end else begin
            step_ptr = p + 8'h01;
        end
    endfunction : step_ptr

    function automatic logic legal_ptr(input logic [7:0] p);
        legal_ptr = (p <= ssap_pkg::REG_HI) ||
                    (p >= ssap_pkg::UEE_LO && p <= ssap_pkg::CEE_HI);
    endfunction : legal_ptr

    // ****************************************
    // link domain: protocol engine
    // ****************************************
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_ptr = ptr;
        next_cmd = cmd;
        next_rw = rw;
        next_brd_armed = brd_armed;
        next_tx_is_cnt = tx_is_cnt;
        next_mack_ok = mack_ok;
        next_sda_oe = sda_oe;
        next_ee_tgl = ee_tgl;
        next_boot_tgl = boot_tgl;
        next_wr = '0;
        if (start_seen) begin
            next_state = ssap_pkg::ST_RX;
            next_phase = ssap_pkg::PH_ADDR;
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_state = ssap_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
            next_brd_armed = 1'b0;
        end else begin
            case (state)
                ssap_pkg::ST_RX: begin
                    if (scl_rise && bitcnt != 4'h8) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        next_sda_oe = 1'b1;
                        next_state = ssap_pkg::ST_ACK;
                        case (phase)
                            ssap_pkg::PH_ADDR: begin
                                next_rw = shreg[0];
                                next_phase = ssap_pkg::PH_CMD;
                                if (shreg[7:4] != ssap_pkg::SLAVE_HI || shreg[3] != ssap_pkg::SLAVE_B3 ||
                                    shreg[2] != sel_s || busy_l) begin
                                    next_sda_oe = 1'b0;
                                end
                            end
                            ssap_pkg::PH_CMD: begin
                                next_brd_armed = (shreg == ssap_pkg::CMD_BRD);
                                next_phase = ssap_pkg::PH_IGNORE;
                                if (busy_l) begin
                                    next_sda_oe = 1'b0;
                                    next_brd_armed = 1'b0;
                                end else if (shreg == ssap_pkg::CMD_BWR) begin
                                    next_phase = ssap_pkg::PH_CNT;
                                end else if (shreg == ssap_pkg::CMD_REBOOT) begin
                                    next_boot_tgl = ~boot_tgl;
                                end else if (shreg == ssap_pkg::CMD_BRD) begin
                                    next_phase = ssap_pkg::PH_IGNORE;
                                end else if (legal_ptr(shreg)) begin
                                    next_ptr = shreg;
                                    next_cmd = shreg;
                                    next_phase = ssap_pkg::PH_DATA;
                                end else begin
                                    next_sda_oe = 1'b0;
                                end
                            end
                            ssap_pkg::PH_DATA: begin
                                next_phase = ssap_pkg::PH_IGNORE;
                                if (cmd >= ssap_pkg::PRESET_LO && cmd <= ssap_pkg::PRESET_HI) begin
                                    next_ptr = shreg;
                                end else if (cmd != ssap_pkg::REG_HI) begin
                                    next_wr = '{en: 1'b1, addr: cmd, data: shreg};
                                    next_ee_tgl = (cmd >= ssap_pkg::UEE_LO) ? ~ee_tgl : ee_tgl;
                                end
                            end
                            ssap_pkg::PH_CNT: begin
                                next_phase = ssap_pkg::PH_BDATA;
                            end
                            ssap_pkg::PH_BDATA: begin
                                // read-only top register swallows the byte
                                if (ptr != ssap_pkg::REG_HI && legal_ptr(ptr)) begin
                                    next_wr = '{en: 1'b1, addr: ptr, data: shreg};
                                    next_ee_tgl = (ptr >= ssap_pkg::UEE_LO) ? ~ee_tgl : ee_tgl;
                                end
                                next_ptr = step_ptr(ptr);
                            end
                            default: begin
                                next_sda_oe = 1'b0;
                            end
                        endcase
                        if (!next_sda_oe) begin
                            next_state = ssap_pkg::ST_IDLE;
                        end
                    end
                end
                ssap_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        next_bitcnt = 4'h0;
                        next_sda_oe = 1'b0;
                        next_state = ssap_pkg::ST_RX;
                        if (phase == ssap_pkg::PH_CMD && rw) begin
                            // read address: first byte is count or data
                            next_tx_is_cnt = brd_armed;
                            next_shreg = brd_armed ? ssap_pkg::BRD_COUNT : rdata;
                            next_sda_oe = ~next_shreg[7];
                            next_bitcnt = 4'h1;
                            next_state = ssap_pkg::ST_TX;
                        end
                    end
                end
                ssap_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            next_sda_oe = 1'b0;
                            next_state = ssap_pkg::ST_MACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_oe = ~shreg[6];
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                ssap_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        if (!tx_is_cnt) begin
                            next_ptr = step_ptr(ptr);
                        end
                        next_tx_is_cnt = 1'b0;
                        next_mack_ok = ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_ok && brd_armed) begin
                            next_shreg = rdata;
                            next_sda_oe = ~rdata[7];
                            next_bitcnt = 4'h1;
                            next_state = ssap_pkg::ST_TX;
                        end else begin
                            next_state = ssap_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_l) begin
            state <= ssap_pkg::ST_IDLE;
            phase <= ssap_pkg::PH_ADDR;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            ptr <= ssap_pkg::PTR_RESET;
            cmd <= ssap_pkg::PTR_RESET;
            rw <= 1'b0;
            brd_armed <= 1'b0;
            tx_is_cnt <= 1'b0;
            mack_ok <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            ee_tgl <= 1'b0;
            boot_tgl <= 1'b0;
            wr <= '0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state <= next_state;
            phase <= next_phase;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            ptr <= next_ptr;
            cmd <= next_cmd;
            rw <= next_rw;
            brd_armed <= next_brd_armed;
            tx_is_cnt <= next_tx_is_cnt;
            mack_ok <= next_mack_ok;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            ee_tgl <= next_ee_tgl;
            boot_tgl <= next_boot_tgl;
            wr <= next_wr;
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

endmodule : ssap_top

/* hdl/ssap_pkg.sv */
// constants, types and timing for the two-wire slave access and pointer block
package ssap_pkg;

    // ****************************************
    // slave address
    // ****************************************
    localparam logic [3:0] SLAVE_HI = 4'ha;
    localparam logic SLAVE_B3 = 1'b0;

    // ****************************************
    // memory regions and commands
    // ****************************************
    localparam logic [7:0] REG_LO = 8'h00;
    localparam logic [7:0] REG_HI = 8'h2f;
    localparam logic [7:0] UEE_LO = 8'h40;
    localparam logic [7:0] UEE_HI = 8'h7f;
    localparam logic [7:0] CEE_LO = 8'h80;
    localparam logic [7:0] CEE_HI = 8'h9f;
    localparam logic [7:0] PRESET_LO = 8'h80;
    localparam logic [7:0] PRESET_HI = 8'h82;
    localparam logic [7:0] CMD_BWR = 8'hc0;
    localparam logic [7:0] CMD_BRD = 8'hc1;
    localparam logic [7:0] CMD_REBOOT = 8'hc4;
    localparam logic [7:0] BRD_COUNT = 8'h10;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int REF_CLK_KHZ = 20000;
    localparam int BOOT_TIME_US = 2500;
    localparam int BOOT_CYCLES = BOOT_TIME_US * REF_CLK_KHZ / 1000;
    localparam int EE_WRITE_TIME_US = 10;
    localparam int EE_WRITE_CYCLES = EE_WRITE_TIME_US * REF_CLK_KHZ / 1000;
    localparam int TIMER_W = 16;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100
    } ssap_state_t;

    typedef enum logic [2:0] {
        PH_ADDR = 3'b000,
        PH_CMD = 3'b001,
        PH_DATA = 3'b010,
        PH_CNT = 3'b011,
        PH_BDATA = 3'b100,
        PH_IGNORE = 3'b101
    } ssap_phase_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } ssap_mem_wr_t;

endpackage : ssap_pkg

/* hdl/ssap_sync.sv */
// two flip-flop level synchroniser, any width
`timescale 1ns/10ps
module ssap_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end
endmodule : ssap_sync

/* hdl/ssap_mem.sv */
// byte memory behind the pointer, registered read data
`timescale 1ns/10ps
module ssap_mem #(
    parameter int AW = 8
) (
    input wire logic clk,
    input ssap_pkg::ssap_mem_wr_t wr,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr.en) begin
            cells[wr.addr[AW-1:0]] <= wr.data;
        end
        rdata <= cells[raddr];
    end
endmodule : ssap_mem

/* verif/ssap_checker.sv */
// assertions on the top ports of the two-wire slave block
`timescale 1ns/10ps
module ssap_checker #(
    parameter int BOOT_CYCLES = 200,
    parameter int EE_WRITE_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic address_select_pin,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic busy
);
    // ****
    // helper counters
    // ****
    int up_cnt;
    int next_up_cnt;
    int idle_cnt;
    int next_idle_cnt;
    int low_cnt;
    int next_low_cnt;
    always_comb begin
        next_up_cnt = (up_cnt < BOOT_CYCLES) ? up_cnt + 1 : up_cnt;
        next_idle_cnt = (busy && scl) ? idle_cnt + 1 : 0;
        // saturates so a parked low clock cannot wrap it
        next_low_cnt = scl ? 0 : ((low_cnt < 15) ? low_cnt + 1 : low_cnt);
    end
    always_ff @(posedge ref_clk) begin
        up_cnt <= rst ? 0 : next_up_cnt;
        idle_cnt <= rst ? 0 : next_idle_cnt;
    end
    always_ff @(posedge link_clk) begin
        low_cnt <= next_low_cnt;
    end
    // ****
    // assertions
    // ****
    a_out_low: assert property (@(posedge link_clk) disable iff (rst)
        sda_out == 1'b0) else $error("sda_out high");
    a_busy_reset: assert property (@(posedge ref_clk)
        rst |=> busy) else $error("busy low in reset");
    a_boot_busy: assert property (@(posedge ref_clk) disable iff (rst)
        up_cnt < BOOT_CYCLES - 1 |-> busy) else $error("boot busy short");
    a_busy_bounded: assert property (@(posedge ref_clk) disable iff (rst)
        idle_cnt <= BOOT_CYCLES + EE_WRITE_CYCLES + 8) else $error("busy stuck");
    a_oe_steady_high: assert property (@(posedge link_clk) disable iff (rst)
        scl && $past(scl) |-> $stable(sda_oe)) else $error("sda moved in clock high");
    a_oe_rise_time: assert property (@(posedge link_clk) disable iff (rst)
        $rose(sda_oe) |-> low_cnt inside {[1:8]}) else $error("late drive");
    a_oe_fall_time: assert property (@(posedge link_clk) disable iff (rst)
        $fell(sda_oe) |-> low_cnt inside {[1:8]}) else $error("late release");
    a_oe_reset: assert property (@(posedge link_clk)
        rst [*4] |=> !sda_oe) else $error("sda driven in reset");
    c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
    c_boot_end: cover property (@(posedge ref_clk) $fell(busy));
    c_long_busy: cover property (@(posedge ref_clk) idle_cnt > EE_WRITE_CYCLES);
endmodule : ssap_checker

bind ssap_top ssap_checker #(.BOOT_CYCLES(BOOT_CYCLES), .EE_WRITE_CYCLES(EE_WRITE_CYCLES)) chk_u (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl(scl), .sda_in(sda_in),
    .address_select_pin(address_select_pin), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));

/* verif/ssap_master_model.sv */
// two-wire bus master model driving clock and data
`timescale 1ns/10ps
module ssap_master_model (
    input wire logic link_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_in
);
    // ****
    // wire and bit timing
    // ****
    logic sda_m = 1'b1;
    initial scl = 1'b1;
    // pull-up: released line reads high
    assign sda_in = sda_m & ~sda_oe;
    task automatic wait_n(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask : wait_n
    // data moves well after the clock fall, never beside it
    task automatic bit_io(input logic b, output logic r);
        wait_n(4);
        sda_m = b;
        wait_n(12);
        scl = 1'b1;
        wait_n(12);
        r = sda_in;
        scl = 1'b0;
    endtask : bit_io
    task automatic start_c;
        wait_n(4);
        sda_m = 1'b1;
        wait_n(12);
        scl = 1'b1;
        wait_n(12);
        sda_m = 1'b0;
        wait_n(12);
        scl = 1'b0;
    endtask : start_c
    task automatic stop_c;
        wait_n(4);
        sda_m = 1'b0;
        wait_n(12);
        scl = 1'b1;
        wait_n(12);
        sda_m = 1'b1;
        wait_n(12);
    endtask : stop_c
    // msb first; mack is the master's answer bit, 1 on writes
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(mack, ack);
    endtask : xfer
endmodule : ssap_master_model

/* verif/ssap_bench.sv */
// self-checking bench for the two-wire slave block
`timescale 1ns/10ps
module ssap_bench;
    // ****
    // harness
    // ****
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic address_select_pin = 1'b1;
    logic scl;
    logic sda_in;
    logic sda_oe;
    logic sda_out;
    logic busy;
    int fail_count = 0;
    int n_tests = 0;
    // select pin tied high gives these address bytes
    localparam logic [7:0] AW = 8'ha4;
    localparam logic [7:0] AR = 8'ha5;
    always #25 ref_clk = ~ref_clk;
    always #16 link_clk = ~link_clk;
    // long boot so a reboot is still running when the next address lands
    ssap_top #(.BOOT_CYCLES(600), .EE_WRITE_CYCLES(20)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl(scl), .sda_in(sda_in),
        .address_select_pin(address_select_pin), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
    ssap_master_model mm_u (.link_clk(link_clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // e: expected answer bit, 0 is ack
    task automatic wb(input logic [7:0] d, input logic e);
        logic [7:0] q;
        logic a;
        mm_u.xfer(d, 1'b1, q, a);
        chk({7'h00, a}, {7'h00, e});
    endtask : wb
    task automatic rb(input logic [7:0] e, input logic mack);
        logic [7:0] q;
        logic a;
        mm_u.xfer(8'hff, mack, q, a);
        chk(q, e);
    endtask : rb
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0) begin
            @(posedge ref_clk);
            k++;
            if (k > 2000) begin
                fail_count++;
                give_verdict();
            end
        end
    endtask : wait_idle
    task automatic send_byte(input logic [7:0] p);
        mm_u.start_c();
        wb(AW, 1'b0);
        wb(p, 1'b0);
        mm_u.stop_c();
    endtask : send_byte
    task automatic wr_byte(input logic [7:0] c, input logic [7:0] d);
        mm_u.start_c();
        wb(AW, 1'b0);
        wb(c, 1'b0);
        wb(d, 1'b0);
        mm_u.stop_c();
        wait_idle();
    endtask : wr_byte
    task automatic recv(input logic [7:0] e);
        mm_u.start_c();
        wb(AR, 1'b0);
        rb(e, 1'b1);
        mm_u.stop_c();
    endtask : recv
    task automatic blk_wr(input logic [31:0] d);
        mm_u.start_c();
        wb(AW, 1'b0);
        wb(8'hc0, 1'b0);
        wb(8'h04, 1'b0);
        for (int i = 3; i >= 0; i--) begin
            wb(d[i*8 +: 8], 1'b0);
        end
        mm_u.stop_c();
        wait_idle();
    endtask : blk_wr
    task automatic blk_rd_hdr(input logic [7:0] p);
        send_byte(p);
        mm_u.start_c();
        wb(AW, 1'b0);
        wb(8'hc1, 1'b0);
        mm_u.start_c();
        wb(AR, 1'b0);
        rb(8'h10, 1'b0);
    endtask : blk_rd_hdr
    // ****
    // scenarios
    // ****
    task automatic t_boot;
        // look after the edge has settled, not beside it
        #1;
        chk({7'h00, busy}, 8'h01);
        chk({7'h00, sda_out}, 8'h00);
        mm_u.start_c();
        wb(AW, 1'b1);
        mm_u.stop_c();
        wait_idle();
        $display("boot done");
    endtask : t_boot
    task automatic t_wr_rd;
        wr_byte(8'h05, 8'h3c);
        wr_byte(8'h06, 8'h5a);
        mm_u.start_c();
        wb(AW, 1'b0);
        wb(8'h05, 1'b0);
        mm_u.start_c();
        wb(AR, 1'b0);
        rb(8'h3c, 1'b1);
        mm_u.stop_c();
        recv(8'h5a);
        $display("write and read done");
    endtask : t_wr_rd
    task automatic t_illegal;
        logic [7:0] bad [4] = '{8'h30, 8'h3f, 8'ha0, 8'hc2};
        send_byte(8'h05);
        foreach (bad[i]) begin
            mm_u.start_c();
            wb(AW, 1'b0);
            wb(bad[i], 1'b1);
            mm_u.stop_c();
        end
        recv(8'h3c);
        mm_u.start_c();
        wb(8'ha0, 1'b1);
        mm_u.start_c();
        wb(8'ha6, 1'b0);
        mm_u.stop_c();
        $display("refusals done");
    endtask : t_illegal
    task automatic t_blocks;
        send_byte(8'h2d);
        blk_wr(32'h11223344);
        blk_rd_hdr(8'h2d);
        rb(8'h11, 1'b0);
        rb(8'h22, 1'b1);
        mm_u.stop_c();
        send_byte(8'h7e);
        blk_wr(32'ha1a2a3a4);
        blk_rd_hdr(8'h7e);
        rb(8'ha1, 1'b0);
        rb(8'ha2, 1'b0);
        rb(8'ha3, 1'b0);
        rb(8'ha4, 1'b1);
        mm_u.stop_c();
        $display("blocks done");
    endtask : t_blocks
    task automatic t_cfg_top;
        wr_byte(8'h80, 8'h9d);
        blk_wr(32'hb1b2b3b4);
        send_byte(8'h9d);
        recv(8'hb1);
        recv(8'hb2);
        recv(8'hb4);
        recv(8'hb4);
        $display("config top done");
    endtask : t_cfg_top
    task automatic t_reboot;
        send_byte(8'hc4);
        chk({7'h00, busy}, 8'h01);
        mm_u.start_c();
        wb(AW, 1'b1);
        mm_u.stop_c();
        wait_idle();
        $display("reboot done");
    endtask : t_reboot
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_boot();
        t_wr_rd();
        t_illegal();
        t_blocks();
        t_cfg_top();
        t_reboot();
        give_verdict();
    end
endmodule : ssap_bench
